//--- core/csp_defs.vh
// Constants for the clocked serial port block
`ifndef CSP_DEFS_VH
`define CSP_DEFS_VH

// Register indices, byte address is four times the index
`define CSP_IDX_CTRL 16'hFF70
`define CSP_IDX_CFG 16'hFF71
`define CSP_IDX_SDLO 16'hFF72
`define CSP_IDX_SDHI 16'hFF73
`define CSP_IDX_MASK 16'hFFE3
`define CSP_IDX_FLAG 16'hFFF3

// Control register fields
`define CSP_CTRL_ESEL 0
`define CSP_CTRL_TRIG 1
`define CSP_CTRL_TXEN 2
// Config register fields
`define CSP_CFG_SRC_LO 0
`define CSP_CFG_SRC_HI 1
`define CSP_CFG_EDGE 2
`define CSP_CFG_ORDER 3
// Mask and flag bit
`define CSP_IRQ_BIT 0

// Clock source codes
`define CSP_SRC_SLAVE 2'h0
`define CSP_SRC_TIMER 2'h1
`define CSP_SRC_OSC_HALF 2'h2
`define CSP_SRC_OSC 2'h3

// Reset values and counts
`define CSP_RST_NIB 4'h0
`define CSP_RST_BYTE 8'h00
`define CSP_LAST_BIT 4'h7
`define CSP_PORT_IN 4'hF

`endif

//--- core/csp_ahb_slave.v
// AHB-Lite slave front end with one wait state per transfer
`timescale 1ns/1ns
module csp_ahb_slave
(
   input wire clock,
   input wire rst,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hready,
   output reg hreadyout,
   output reg [15:0] idx_r,
   output wire wr_stb,
   output wire rd_stb
);

   reg phase_r;
   reg write_r;

   // Address phase capture, then one stalled data-phase cycle
   always @(posedge clock)
   begin
      if (rst)
      begin
         phase_r <= 1'b0;
         write_r <= 1'b0;
         idx_r <= 16'h0000;
         hreadyout <= 1'b1;
      end
      else if (phase_r)
      begin
         phase_r <= 1'b0;
         hreadyout <= 1'b1;
      end
      else if (hsel && htrans[1] && hready)
      begin
         phase_r <= 1'b1;
         write_r <= hwrite;
         idx_r <= haddr[17:2];
         hreadyout <= 1'b0;
      end
   end

   // Strobes land in the stalled cycle, hwdata already valid
   assign wr_stb = phase_r & write_r;
   assign rd_stb = phase_r & ~write_r;

endmodule // csp_ahb_slave

//--- core/csp_clk_gen.v
// Half-period tick generator for the master shift clock
`timescale 1ns/1ns
`include "csp_defs.vh"
module csp_clk_gen
(
   input wire clock,
   input wire rst,
   input wire [1:0] src_sel,
   input wire osc_edge,
   input wire tmr1_underflow,
   output reg tick_r
);

   reg osc_half_r;

   // Divides oscillator edges by two for the halved source
   always @(posedge clock)
   begin
      if (rst)
         osc_half_r <= 1'b0;
      else if (osc_edge)
         osc_half_r <= ~osc_half_r;
   end

   // Each tick during a transfer toggles the shift clock; halved oscillator source ticks on every second edge
   always @(posedge clock)
   begin
      if (rst)
         tick_r <= 1'b0;
      else
      begin
         case (src_sel)
            `CSP_SRC_OSC: tick_r <= osc_edge;
            `CSP_SRC_OSC_HALF: tick_r <= osc_edge & osc_half_r;
            `CSP_SRC_TIMER: tick_r <= tmr1_underflow;
            default: tick_r <= 1'b0;
         endcase
      end
   end

endmodule // csp_clk_gen

//--- core/csp_top.v
// Clocked 8-bit serial port with AHB-Lite register access
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ns
`include "csp_defs.vh"
module csp_top
#(
   parameter POS_POLARITY = 1'b0
)
(
   input wire clock,
   input wire rst,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output wire hreadyout,
   output reg hresp,
   input wire low_speed_osc_edge,
   input wire tmr1_underflow,
   input wire [3:0] port1_in,
   input wire [3:0] gpio_out,
   input wire [3:0] gpio_drive,
   output reg [3:0] port1_out_r,
   output reg [3:0] port1_oe_n_r,
   output reg irq_r
);

   // Bit that leaves the register next, per bit order
   function out_bit;
      input [7:0] sr;
      input msb_first;
      begin
         out_bit = msb_first ? sr[7] : sr[0];
      end
   endfunction

   // Shift one bit in at the far end, per bit order
   function [7:0] shift_in;
      input [7:0] sr;
      input din;
      input msb_first;
      begin
         shift_in = msb_first ? {sr[6:0], din} : {din, sr[7:1]};
      end
   endfunction

   // Converts an active level to the pin level
   function pin_level;
      input act;
      begin
         pin_level = POS_POLARITY ? act : ~act;
      end
   endfunction

   // Bus front end
   wire [15:0] idx;
   wire wr_stb;
   wire rd_stb;

   csp_ahb_slave u_bus
   (
      .clock(clock),
      .rst(rst),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hready(hready),
      .hreadyout(hreadyout),
      .idx_r(idx),
      .wr_stb(wr_stb),
      .rd_stb(rd_stb)
   );

   // Software-visible state
   reg esel_r;
   reg txen_r;
   reg [1:0] src_r;
   reg edge_r;
   reg order_r;
   reg mask_r;
   reg flag_r;
   reg flag_nxt;

   // Transfer state
   reg [7:0] sr_r;
   reg [7:0] sr_nxt;
   reg out_r;
   reg [3:0] cnt_r;
   reg run_r;
   reg act_r;
   reg seen_r;
   reg ready_r;
   reg ext_prev_r;

   // Master tick generator
   wire tick;

   csp_clk_gen u_clk
   (
      .clock(clock),
      .rst(rst),
      .src_sel(src_r),
      .osc_edge(low_speed_osc_edge),
      .tmr1_underflow(tmr1_underflow),
      .tick_r(tick)
   );

   // Register access decode
   wire wr_ctrl = wr_stb && (idx == `CSP_IDX_CTRL);
   wire wr_cfg = wr_stb && (idx == `CSP_IDX_CFG);
   wire wr_lo = wr_stb && (idx == `CSP_IDX_SDLO);
   wire wr_hi = wr_stb && (idx == `CSP_IDX_SDHI);
   wire wr_mask = wr_stb && (idx == `CSP_IDX_MASK);
   wire wr_flag = wr_stb && (idx == `CSP_IDX_FLAG);
   wire hi_touch = (wr_stb || rd_stb) && (idx == `CSP_IDX_SDHI);
   wire start = wr_ctrl && hwdata[`CSP_CTRL_TRIG];

   // Mode and clock edges
   wire master = (src_r != `CSP_SRC_SLAVE);
   wire ext_act = POS_POLARITY ? port1_in[2] : ~port1_in[2];

   // Master: leading edge only while running, so no ninth pulse
   wire lead_m = tick && run_r && !act_r;
   wire trail_m = tick && act_r;

   // Slave: edges count only during a transfer
   wire lead_s = run_r && ext_act && !ext_prev_r;
   wire trail_s = run_r && !ext_act && ext_prev_r;

   wire lead = master ? lead_m : lead_s;
   wire trail_any = master ? trail_m : trail_s;
   // A trailing edge before any leading edge is not a cycle
   wire trail = trail_any && seen_r && run_r;

   // Sample edge: leading edge if phase bit set, else trailing
   wire samp = edge_r ? lead : trail;

   // Transfer ends at eighth trailing edge, so last pulse completes
   wire done = trail && (cnt_r == `CSP_LAST_BIT);

   // Shift register next value
   always @*
   begin
      sr_nxt = sr_r;
      if (samp)
         sr_nxt = shift_in(sr_r, port1_in[0], order_r);
      if (wr_lo)
         sr_nxt[3:0] = hwdata[3:0];
      if (wr_hi)
         sr_nxt[7:4] = hwdata[3:0];
   end

   // Completion wins over a same-cycle write-one clear
   always @*
   begin
      flag_nxt = flag_r;
      if (wr_flag && hwdata[`CSP_IRQ_BIT])
         flag_nxt = 1'b0;
      if (done)
         flag_nxt = 1'b1;
   end

   // Configuration and control registers
   always @(posedge clock)
   begin
      if (rst)
      begin
         esel_r <= 1'b0;
         txen_r <= 1'b0;
         src_r <= `CSP_SRC_SLAVE;
         edge_r <= 1'b0;
         order_r <= 1'b0;
         mask_r <= 1'b0;
      end
      else
      begin
         if (wr_ctrl)
         begin
            esel_r <= hwdata[`CSP_CTRL_ESEL];
            txen_r <= hwdata[`CSP_CTRL_TXEN];
         end
         if (wr_cfg)
         begin
            src_r <= hwdata[`CSP_CFG_SRC_HI:`CSP_CFG_SRC_LO];
            edge_r <= hwdata[`CSP_CFG_EDGE];
            order_r <= hwdata[`CSP_CFG_ORDER];
         end
         if (wr_mask)
            mask_r <= hwdata[`CSP_IRQ_BIT];
      end
   end

   // Done flag, set and clear resolved above
   always @(posedge clock)
   begin
      if (rst)
         flag_r <= 1'b0;
      else
         flag_r <= flag_nxt;
   end

   // Shift register, pin history and output bit
   always @(posedge clock)
   begin
      if (rst)
      begin
         sr_r <= `CSP_RST_BYTE;
         out_r <= 1'b0;
         ext_prev_r <= 1'b0;
      end
      else
      begin
         sr_r <= sr_nxt;
         ext_prev_r <= ext_act;
         // Output changes on the leading edge of each cycle
         if (lead)
            out_r <= out_bit(sr_r, order_r);
      end
   end

   // Master clock toggles per tick, returns to idle
   always @(posedge clock)
   begin
      if (rst)
         act_r <= 1'b0;
      else if (lead_m)
         act_r <= 1'b1;
      else if (trail_m || !master)
         act_r <= 1'b0;
   end

   // Run flag and cycle count, one count per trailing edge
   always @(posedge clock)
   begin
      if (rst)
      begin
         cnt_r <= 4'h0;
         run_r <= 1'b0;
         seen_r <= 1'b0;
      end
      else if (start)
      begin
         run_r <= 1'b1;
         cnt_r <= 4'h0;
         seen_r <= 1'b0;
      end
      else
      begin
         if (lead)
            seen_r <= 1'b1;
         if (done)
         begin
            run_r <= 1'b0;
            cnt_r <= 4'h0;
         end
         else if (trail)
            cnt_r <= cnt_r + 4'h1;
      end
   end

   // Ready: set by trigger in slave mode, dropped by clock or high nibble access
   always @(posedge clock)
   begin
      if (rst)
         ready_r <= 1'b0;
      else if (start && !master)
         ready_r <= 1'b1;
      else if (hi_touch || (ext_act && run_r) || master)
         ready_r <= 1'b0;
   end

   // Register read data, captured for the data phase
   always @(posedge clock)
   begin
      if (rst)
      begin
         hrdata <= 32'h00000000;
         hresp <= 1'b0;
      end
      else if (rd_stb)
      begin
         case (idx)
            `CSP_IDX_CTRL: hrdata <= {28'h0000000, 1'b0, txen_r, run_r, esel_r};
            `CSP_IDX_CFG: hrdata <= {28'h0000000, order_r, edge_r, src_r};
            `CSP_IDX_SDLO: hrdata <= {28'h0000000, sr_r[3:0]};
            `CSP_IDX_SDHI: hrdata <= {28'h0000000, sr_r[7:4]};
            `CSP_IDX_MASK: hrdata <= {31'h00000000, mask_r};
            `CSP_IDX_FLAG: hrdata <= {31'h00000000, flag_r};
            default: hrdata <= 32'h00000000;
         endcase
      end
   end

   // Pin levels of shift clock and ready, per build polarity
   wire clk_lvl = pin_level(act_r);
   wire rdy_lvl = pin_level(ready_r);

   // Pin function mux, registered onto the pins
   reg [3:0] pin_nxt;
   reg [3:0] oe_n_nxt;

   always @*
   begin
      pin_nxt = gpio_out;
      oe_n_nxt = ~gpio_drive;
      if (esel_r)
      begin
         // Bit 0: serial input, never driven
         pin_nxt[0] = 1'b1;
         oe_n_nxt[0] = 1'b1;
         // Bit 1: serial output through tri-state
         pin_nxt[1] = out_r;
         oe_n_nxt[1] = ~txen_r;
         // Bit 2: shift clock, out in master, in in slave
         pin_nxt[2] = clk_lvl;
         oe_n_nxt[2] = ~master;
         // Bit 3: ready in slave, plain port in master
         if (!master)
         begin
            pin_nxt[3] = rdy_lvl;
            oe_n_nxt[3] = 1'b0;
         end
      end
   end

   // Output flops; ports released during reset
   always @(posedge clock)
   begin
      if (rst)
      begin
         port1_out_r <= `CSP_PORT_IN;
         port1_oe_n_r <= `CSP_PORT_IN;
         irq_r <= 1'b0;
      end
      else
      begin
         port1_out_r <= pin_nxt;
         port1_oe_n_r <= oe_n_nxt;
         irq_r <= flag_r && mask_r;
      end
   end

endmodule // csp_top

//--- dv/csp_asserts.sv
// Pin and interrupt assertions for the serial port, driven from bus decode
`timescale 1ns/1ns
`include "csp_defs.vh"
module csp_asserts
(
   input wire clock,
   input wire rst,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hready,
   input wire [31:0] hwdata,
   input wire [3:0] gpio_drive,
   input wire [3:0] port1_out_r,
   input wire [3:0] port1_oe_n_r,
   input wire hreadyout,
   input wire irq_r
);
   reg wp_r;
   reg fn_r;
   reg tx_r;
   reg [1:0] src_r;
   reg [15:0] ix_r;
   wire sl = fn_r && src_r == `CSP_SRC_SLAVE;
   wire ms = fn_r && src_r != `CSP_SRC_SLAVE;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // Shadow of function, drive and source bits taken from bus writes
   always @(posedge clock)
   begin
      wp_r <= !rst && hsel && htrans[1] && hready && hwrite;
      if (hready)
         ix_r <= haddr[17:2];
      if (rst)
      begin
         fn_r <= 1'b0;
         tx_r <= 1'b0;
         src_r <= 2'h0;
      end
      else if (wp_r && ix_r == `CSP_IDX_CTRL)
      begin
         fn_r <= hwdata[0];
         tx_r <= hwdata[2];
      end
      else if (wp_r && ix_r == `CSP_IDX_CFG)
         src_r <= hwdata[1:0];
   end
   a_rst_vals: assert property ($past(rst) |-> hreadyout && !irq_r && port1_oe_n_r == 4'hF)
      else $error("not idle after reset");
   a_pins_gpio: assert property ((!fn_r && $stable(gpio_drive))[*3] |-> port1_oe_n_r == ~gpio_drive)
      else $error("port drive wrong");
   a_sin_input: assert property (fn_r[*2] |-> port1_oe_n_r[0])
      else $error("serial input driven");
   a_clk_out: assert property (ms[*3] |-> !port1_oe_n_r[2])
      else $error("master clock not driven");
   a_clk_in: assert property (sl[*3] |-> port1_oe_n_r[2])
      else $error("slave clock driven");
   a_bit3_gpio: assert property ((ms && $stable(gpio_drive))[*3] |-> port1_oe_n_r[3] == !gpio_drive[3])
      else $error("bit 3 not port in master");
   a_ready_drv: assert property (sl[*3] |-> !port1_oe_n_r[3])
      else $error("ready not driven");
   a_serial_out_pin_tri: assert property ((fn_r && !tx_r)[*3] |-> port1_oe_n_r[1])
      else $error("output not released");
   a_irq_clear: assert property (wp_r && ix_r == `CSP_IDX_FLAG && hwdata[0] |-> ##[1:3] !irq_r)
      else $error("request not cleared");
   cover property ($rose(irq_r));
   cover property (sl && !port1_out_r[3]);
   cover property (ms && $fell(port1_out_r[2]));
endmodule // csp_asserts

//--- dv/csp_partner.sv
// Far-side serial device: clock master in slave mode, data both ways
`timescale 1ns/1ns
module csp_partner
(
   input wire clock,
   input wire clk_pin,
   input wire serial_out_pin,
   output logic serial_in_pin,
   output logic sclk,
   output logic [7:0] rx,
   output logic [3:0] nfall
);
   logic [7:0] tb_b = 8'h00;
   logic msb = 1'b0;
   logic lead = 1'b0;
   logic armed = 1'b0;
   logic prev = 1'b1;
   integer ns = 8;
   integer nr = 8;
   integer dly = 0;
   initial
   begin
      serial_in_pin = 1'b0;
      sclk = 1'b1;
      rx = 8'h00;
      nfall = 4'h0;
   end
   function automatic integer bi(input integer n);
      bi = msb ? 7 - n : n;
   endfunction
   // Load a byte and its bit order for the next frame
   task arm(input logic [7:0] b, input logic m, input logic l);
   begin
      repeat (2) @(posedge clock);
      tb_b = b;
      msb = m;
      lead = l;
      ns = 0;
      nr = 0;
      armed = 1'b1;
      nfall <= 4'h0;
      serial_in_pin <= m ? b[7] : b[0];
   end
   endtask
   // Slow external clock, idle high
   task pulses(input integer n);
      integer k;
   begin
      for (k = 0; k < 2 * n; k++)
      begin
         repeat (8) @(posedge clock);
         sclk <= ~sclk;
      end
   end
   endtask
   // Take output on trailing edges, move input on after sample edges
   always @(posedge clock)
   begin
      prev <= clk_pin;
      if (clk_pin !== prev && !clk_pin)
         nfall <= nfall + 4'h1;
      if (clk_pin !== prev && clk_pin && nr < 8)
      begin
         rx[bi(nr)] <= serial_out_pin;
         nr = nr + 1;
      end
      if (clk_pin !== prev && clk_pin != lead && ns < 8)
      begin
         ns = ns + 1;
         dly = 3;
      end
      if (dly == 1 && ns < 8)
         serial_in_pin <= tb_b[bi(ns)];
      if (dly == 1 && ns == 8)
         armed = 1'b0;
      if (dly > 0)
         dly = dly - 1;
      else if (!armed)
         serial_in_pin <= ~serial_in_pin; // No stale level between frames
   end
endmodule // csp_partner

//--- dv/tb_clocked_serial_port_8bit.sv
// Self-checking bench: bus master, serial partner, expected data
`timescale 1ns/1ns
`include "csp_defs.vh"
module tb_clocked_serial_port_8bit;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic osc = 1'b0;
   logic tmr = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [3:0] gout = 4'h0;
   logic [3:0] gdrv = 4'h0;
   wire [31:0] hrdata;
   wire hready;
   wire irq_r;
   wire serial_in_pin;
   wire sclk;
   wire [3:0] pout;
   wire [3:0] poe_n;
   wire [3:0] pin;
   wire [7:0] prx;
   wire [3:0] nfall;
   integer n_errors = 0;
   integer checks = 0;
   integer cyc = 0;
   integer seed = 68;
   // Pin levels: pull-ups on released bits 3 and 1, partner clock on released bit 2, bit 0 from the partner only
   assign pin = {poe_n[3] | pout[3], poe_n[2] ? sclk : pout[2], poe_n[1] | pout[1], serial_in_pin};
   csp_top #(.POS_POLARITY(1'b0)) dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hready), .hresp(), .low_speed_osc_edge(osc),
      .tmr1_underflow(tmr), .port1_in(pin), .gpio_out(gout), .gpio_drive(gdrv),
      .port1_out_r(pout), .port1_oe_n_r(poe_n), .irq_r(irq_r));
   csp_partner pal (.clock(clock), .clk_pin(pin[2]), .serial_out_pin(pin[1]), .serial_in_pin(serial_in_pin), .sclk(sclk),
      .rx(prx), .nfall(nfall));
   always #2 clock = ~clock;
   // Oscillator and timer pulses, hang guard
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      osc <= cyc % 8 == 0;
      tmr <= cyc % 8 == 4;
      if (cyc == 40000)
      begin
         n_errors = n_errors + 1;
         tally_and_finish;
      end
   end
   task tally_and_finish;
   begin
      if (n_errors == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   end
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
   begin
      checks = checks + 1;
      if (seen !== exp)
      begin
         n_errors = n_errors + 1;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   end
   endtask
   task bus(input logic w, input logic [15:0] ix, input logic [3:0] d, output logic [31:0] r);
   begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {14'h0, ix, 2'h0};
      do @(posedge clock); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {28'h0, d};
      do @(posedge clock); while (hready !== 1'b1);
      r = hrdata;
   end
   endtask
   task wr(input logic [15:0] ix, input logic [3:0] d);
      logic [31:0] r;
      bus(1'b1, ix, d, r);
   endtask
   task rc(input logic [15:0] ix, input logic [31:0] e);
      logic [31:0] r;
   begin
      bus(1'b0, ix, 4'h0, r);
      chk(r, e);
   end
   endtask
   // Reset, then transfers over every source, edge and order
   initial
   begin : main
      logic [31:0] r;
      logic [7:0] tx;
      logic [7:0] pb;
      logic [1:0] src;
      integer i;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      gout <= $random(seed);
      gdrv <= $random(seed);
      @(posedge clock);
      rc(`CSP_IDX_CTRL, 32'h0);
      rc(`CSP_IDX_CFG, 32'h0);
      wr(16'h0123, 4'hF);
      rc(16'h0123, 32'h0);
      chk({poe_n, pout & gdrv}, {~gdrv, gout & gdrv});
      for (i = 0; i < 8; i++)
      begin
         src = 2'h3 - i[1:0];
         tx = $random(seed);
         pb = $random(seed);
         wr(`CSP_IDX_CFG, {i[0] ^ i[2], i[2], src});
         wr(`CSP_IDX_SDLO, tx[3:0]);
         wr(`CSP_IDX_SDHI, tx[7:4]);
         wr(`CSP_IDX_MASK, {3'h0, i[0]});
         wr(`CSP_IDX_CTRL, 4'h5);
         pal.arm(pb, i[0] ^ i[2], i[2]);
         wr(`CSP_IDX_CTRL, 4'h7);
         rc(`CSP_IDX_CTRL, 32'h7);
         chk(poe_n[1:0], 2'h1);
         if (src == 2'h0)
         begin
            chk(pout[3], 1'b0);
            if (i[2])
            begin
               rc(`CSP_IDX_SDHI, tx[7:4]);
               @(posedge clock);
               chk(pout[3], 1'b1);
            end
            pal.pulses(10);
            chk(pout[3], 1'b1);
         end
         do
            bus(1'b0, `CSP_IDX_CTRL, 4'h0, r);
         while (r[1] === 1'b1);
         repeat (3) @(posedge clock);
         chk(r, 32'h5);
         chk(prx, tx);
         rc(`CSP_IDX_SDLO, pb[3:0]);
         rc(`CSP_IDX_SDHI, pb[7:4]);
         rc(`CSP_IDX_FLAG, 32'h1);
         chk(irq_r, i[0]);
         if (src != 2'h0)
            chk({nfall, pin[2]}, 5'h11);
         wr(`CSP_IDX_FLAG, 4'h1);
         rc(`CSP_IDX_FLAG, 32'h0);
      end
      wr(`CSP_IDX_CTRL, 4'h1);
      repeat (4) @(posedge clock);
      chk(poe_n[1], 1'b1);
      tally_and_finish;
   end
endmodule // tb_clocked_serial_port_8bit
bind csp_top csp_asserts u_chk (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .gpio_drive(gpio_drive),
   .port1_out_r(port1_out_r), .port1_oe_n_r(port1_oe_n_r), .hreadyout(hreadyout), .irq_r(irq_r));
